// >>> bench/fir_host_model.sv
// Serial host model that runs frames against the readout.
`timescale 1ns/100ps
module fir_host_model (
    // Host-driven pins.
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      dq_i,
    // Device-driven pins.
    input  wire logic [3:0] dq_o,
    input  wire logic [3:0] oe_n
);
    logic [3:0] hd;
    logic       hen = 1'b0;
    logic       flip = 1'b0;
    logic [7:0] got [0:31];
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // Released lines toggle, so a stale value never passes for data.
    always @(sclk) flip = ~flip;
    assign dq_i = (~oe_n & dq_o) | (oe_n & (hen ? hd : {4{flip}}));
    // One link clock; data is changed only while the clock is low.
    task automatic pulse();
        #24 sclk = 1'b1;
        #24 sclk = 1'b0;
    endtask : pulse
    // Command on w lines, na address and dummy bits on line zero, nb bytes read back.
    task automatic xfer(input logic [7:0] cmd, input int w, input logic [23:0] a,
                        input int na, input int nb, input int om);
        int i;
        int j;
        logic [31:0] sh;
        logic [7:0] b;
        #24 cs_n = 1'b0;
        hen = 1'b1;
        for (i = 0; i < 8 / w; i++) begin
            hd = 4'((cmd >> (8 - w * (i + 1))) & ((1 << w) - 1));
            pulse();
        end
        sh = {a, 8'h00};
        for (i = 0; i < na; i++) begin
            hd = {3'b000, sh[31 - i]};
            pulse();
        end
        hen = 1'b0;
        for (i = 0; i < nb; i++) begin
            b = 8'h00;
            for (j = 0; j < ((om == 1) ? 4 : 8); j++) begin
                #24 sclk = 1'b1;
                b = (om == 1) ? {b[5:0], dq_i[1:0]} : {b[6:0], dq_i[(om == 2) ? 1 : 0]};
                #24 sclk = 1'b0;
            end
            got[i] = b;
        end
        #24 cs_n = 1'b1;
    endtask : xfer
endmodule : fir_host_model

// >>> bench/fir_readout_asserts.sv
// Port checks for the identification readout.
`timescale 1ns/100ps
module fir_readout_asserts (
    // System side.
    input wire logic                clock,
    input wire logic                rst,
    input wire fir_pkg::fir_proto_t proto,
    input wire logic                program_erase_busy,
    // Link side.
    input wire logic                sclk,
    input wire logic                cs_n,
    input wire logic [3:0]          serial_data_lines_o,
    input wire logic [3:0]          serial_data_lines_oe_n,
    input wire logic                select_active_r,
    input wire logic                id_rejected_r
);
    logic [7:0] rise_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Rising link edges in the frame, saturating.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rise_r <= 8'h00;
        end else if (rise_r != 8'hff) begin
            rise_r <= rise_r + 8'h01;
        end
    end
    property p_release;
        cs_n |-> serial_data_lines_oe_n == 4'hf && serial_data_lines_o == 4'h0; endproperty
    a_release: assert property (p_release) else $error("lines driven while deselected");
    property p_single;
        serial_data_lines_oe_n == 4'he |-> rise_r >= 8'h08 && proto == fir_pkg::FIR_PROTO_EXT;
    endproperty
    a_single: assert property (p_single) else $error("early or wrong single-line drive");
    property p_multi;
        serial_data_lines_oe_n == 4'hc |-> rise_r >= 8'h02 && proto != fir_pkg::FIR_PROTO_EXT;
    endproperty
    a_multi: assert property (p_multi) else $error("multi-line drive in wrong protocol");
    property p_table; serial_data_lines_oe_n == 4'hd |-> rise_r >= 8'h28; endproperty
    a_table: assert property (p_table) else $error("table output before dummies end");
    property p_busy;
        serial_data_lines_oe_n inside {4'he, 4'hc} |-> !program_erase_busy; endproperty
    a_busy: assert property (p_busy) else $error("identify answered while busy");
    property p_rej; id_rejected_r |-> program_erase_busy ##1 !id_rejected_r; endproperty
    a_rej: assert property (p_rej) else $error("bad refusal pulse");
    property p_fall; sclk && $past(sclk) && !cs_n |-> $stable(serial_data_lines_o); endproperty
    a_fall: assert property (p_fall) else $error("output moved while link clock high");
    property p_sel; $fell(cs_n) |-> ##[1:4] select_active_r; endproperty
    a_sel: assert property (p_sel) else $error("select not reported");
    property p_desel; $rose(cs_n) |-> ##[1:4] !select_active_r; endproperty
    a_desel: assert property (p_desel) else $error("standby not reported");
endmodule : fir_readout_asserts
bind fir_readout fir_readout_asserts u_chk (.clock(clock), .rst(rst), .proto(proto),
    .program_erase_busy(program_erase_busy), .sclk(sclk), .cs_n(cs_n),
    .serial_data_lines_o(serial_data_lines_o), .serial_data_lines_oe_n(serial_data_lines_oe_n),
    .select_active_r(select_active_r), .id_rejected_r(id_rejected_r));

// >>> bench/tb_fir_readout.sv
// Self-checking bench for the identification readout.
`timescale 1ns/100ps
module tb_fir_readout;
    // Identity bytes with arbitrary values, and the expected table header bytes.
    localparam logic [7:0]   MFR = 8'h3a;
    localparam logic [7:0]   MTY = 8'h4b;
    localparam logic [7:0]   MCA = 8'h5e;
    localparam logic [111:0] FAC = 112'h0102030405060708090a0b0c0d0e;
    localparam logic [7:0]   HDR [0:14] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00,
        8'hff, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00};
    logic                clock = 1'b0;
    logic                rst;
    logic                busy;
    logic                alt;
    logic                pin;
    fir_pkg::fir_proto_t proto;
    logic                sclk;
    logic                cs_n;
    logic [3:0]          dqi;
    logic [3:0]          dqo;
    logic [3:0]          oen;
    logic                sel;
    logic                rej;
    logic                drv = 1'b0;
    logic [7:0]          idb [0:5];
    int                  err_count = 0;
    int                  check_count = 0;
    int                  cyc = 0;
    int                  rejn = 0;
    int                  i;
    int                  k;
    fir_readout #(.MFR_CODE(MFR), .MEM_TYPE(MTY), .MEM_CAPACITY(MCA), .FACTORY_DATA(FAC)) dut (
        .clock(clock), .rst(rst), .proto(proto), .program_erase_busy(busy),
        .alt_protect_scheme(alt), .pin_is_reset(pin), .sclk(sclk), .cs_n(cs_n),
        .serial_data_lines_i(dqi), .serial_data_lines_o(dqo), .serial_data_lines_oe_n(oen),
        .select_active_r(sel), .id_rejected_r(rej));
    fir_host_model host (.sclk(sclk), .cs_n(cs_n), .dq_i(dqi), .dq_o(dqo), .oe_n(oen));
    // System clock at 50 MHz.
    always #10 clock = ~clock;
    // Cycle ceiling, refusal pulses and any drive seen in a frame.
    always @(posedge clock) begin
        cyc++;
        if (rej === 1'b1) rejn++;
        if (oen !== 4'hf) drv = 1'b1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Settings change on a falling edge; an empty frame then clocks them onto the link.
    task automatic cfg(input fir_pkg::fir_proto_t p, input logic b, input logic a, input logic n);
        repeat (4) @(negedge clock);
        proto = p;
        busy = b;
        alt = a;
        pin = n;
        host.xfer(8'h00, 1, 24'h0, 0, 0, 0);
    endtask : cfg
    // Lines must be free once select is high.
    task automatic frame(input logic [7:0] c, input int w, input logic [23:0] a,
                         input int na, input int nb, input int om);
        drv = 1'b0;
        rejn = 0;
        host.xfer(c, w, a, na, nb, om);
        #1 chk({4'h0, oen}, 8'h0f);
    endtask : frame
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        alt = 1'b0;
        pin = 1'b0;
        proto = fir_pkg::FIR_PROTO_EXT;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        cfg(fir_pkg::FIR_PROTO_EXT, 1'b0, 1'b0, 1'b0);
        frame(8'h00, 1, 24'h0, 0, 0, 0);
        // Single-line identify with both settings of the reported bits.
        for (i = 0; i < 2; i++) begin
            cfg(fir_pkg::FIR_PROTO_EXT, 1'b0, i[0], ~i[0]);
            idb = '{MFR, MTY, MCA, 8'h10, {2'b00, i[0], 1'b0, ~i[0], 3'b000}, 8'h00};
            frame(8'h9f, 1, 24'h0, 0, 22, 0);
            for (k = 0; k < 22; k++) begin
                chk(host.got[k], (k < 6) ? idb[k] : (k < 20) ? FAC[111 - 8 * (k - 6) -: 8] : 8'h00);
            end
        end
        // Multi-line identify in dual and quad: three bytes, no unique block.
        for (i = 0; i < 2; i++) begin
            cfg(i ? fir_pkg::FIR_PROTO_QUAD : fir_pkg::FIR_PROTO_DUAL, 1'b0, 1'b0, 1'b0);
            frame(8'haf, i ? 4 : 2, 24'h0, 0, 4, 1);
            idb = '{MFR, MTY, MCA, 8'h00, 8'h00, 8'h00};
            for (k = 0; k < 4; k++) chk(host.got[k], idb[k]);
        end
        // Refused identifies: wrong protocol, then busy in dual and in single-line.
        for (i = 0; i < 4; i++) begin
            cfg(i[0] ? fir_pkg::FIR_PROTO_EXT : fir_pkg::FIR_PROTO_DUAL, i[1], 1'b0, 1'b0);
            frame((i[0] ^ i[1]) ? 8'haf : 8'h9f, i[0] ? 1 : 2, 24'h0, 0, 1, 0);
            chk({7'h0, drv}, 8'h00);
            chk(8'(rejn), {7'h0, i[1]});
        end
        // Table from zero, then across the top boundary with busy set.
        cfg(fir_pkg::FIR_PROTO_EXT, 1'b0, 1'b0, 1'b0);
        frame(8'h5a, 1, 24'h000000, 32, 32, 2);
        for (k = 0; k < 32; k++) chk(host.got[k], (k < 15) ? HDR[k] : 8'hff);
        cfg(fir_pkg::FIR_PROTO_EXT, 1'b1, 1'b0, 1'b0);
        frame(8'h5a, 1, 24'h12f7fe, 32, 4, 2);
        idb = '{8'hff, 8'hff, 8'h53, 8'h46, 8'h00, 8'h00};
        for (k = 0; k < 4; k++) chk(host.got[k], idb[k]);
        end_of_test();
    end
endmodule : tb_fir_readout

// >>> src/fir_pkg.sv
// Shared constants and types for the identification readout block.
package fir_pkg;

    // Bus protocol selection seen at the serial pins.
    typedef enum logic [1:0] {
        FIR_PROTO_EXT  = 2'b00,
        FIR_PROTO_DUAL = 2'b01,
        FIR_PROTO_QUAD = 2'b10
    } fir_proto_t;

    // Configuration and status handed from the system clock to the link.
    typedef struct packed {
        fir_proto_t proto;
        logic       busy;
        logic       alt_protect;
        logic       pin_is_reset;
    } fir_cfg_t;

    // Link sequencer states.
    typedef enum logic [2:0] {
        FIR_ST_CMD    = 3'b000,
        FIR_ST_ADDR   = 3'b001,
        FIR_ST_DUMMY  = 3'b010,
        FIR_ST_ID     = 3'b011,
        FIR_ST_TABLE  = 3'b100,
        FIR_ST_IGNORE = 3'b101
    } fir_state_t;

    // Frame shape: address bits, dummy clocks and table span.
    localparam int unsigned FIR_ADDR_BITS   = 24;
    localparam int unsigned FIR_DUMMY_CLKS  = 8;
    localparam int unsigned FIR_TABLE_AW    = 11;
    localparam logic [4:0]  FIR_ADDR_LAST   = 5'h17;
    localparam logic [4:0]  FIR_DUMMY_LAST  = 5'h07;

    // Identify sequence byte positions and fixed contents.
    localparam logic [4:0]  FIR_IDX_MFR     = 5'h00;
    localparam logic [4:0]  FIR_IDX_TYPE    = 5'h01;
    localparam logic [4:0]  FIR_IDX_CAP     = 5'h02;
    localparam logic [4:0]  FIR_IDX_LEN     = 5'h03;
    localparam logic [4:0]  FIR_IDX_EXT0    = 5'h04;
    localparam logic [4:0]  FIR_IDX_EXT1    = 5'h05;
    localparam logic [4:0]  FIR_IDX_FAC0    = 5'h06;
    localparam logic [4:0]  FIR_IDX_END     = 5'h14;
    localparam logic [7:0]  FIR_UID_LEN     = 8'h10;
    localparam logic [7:0]  FIR_PAST_END    = 8'h00;
    localparam int unsigned FIR_EXT0_ALT    = 5;
    localparam int unsigned FIR_EXT0_PIN    = 3;

    // Discovery table header contents.
    localparam logic [7:0]  FIR_SIG0        = 8'h53;
    localparam logic [7:0]  FIR_SIG1        = 8'h46;
    localparam logic [7:0]  FIR_SIG2        = 8'h44;
    localparam logic [7:0]  FIR_SIG3        = 8'h50;
    localparam logic [7:0]  FIR_REV_MINOR   = 8'h00;
    localparam logic [7:0]  FIR_REV_MAJOR   = 8'h01;
    localparam logic [7:0]  FIR_HDR_COUNT   = 8'h00;
    localparam logic [7:0]  FIR_FILL        = 8'hff;
    localparam logic [7:0]  FIR_PID0        = 8'h00;
    localparam logic [7:0]  FIR_PLEN_DW     = 8'h09;
    localparam logic [7:0]  FIR_PTR_LOW     = 8'h30;
    localparam logic [7:0]  FIR_ZERO        = 8'h00;

    // Output enables, active low, per drive pattern.
    localparam logic [3:0]  FIR_OE_NONE     = 4'hf;
    localparam logic [3:0]  FIR_OE_LINE0    = 4'he;
    localparam logic [3:0]  FIR_OE_LINE1    = 4'hd;
    localparam logic [3:0]  FIR_OE_LINES01  = 4'hc;

endpackage : fir_pkg

// >>> src/fir_readout.sv
// Identification and discovery-table readout of a serial flash.
`timescale 1ns/100ps
// How it works
// RULE1: Select low plus identify code starts readout.
// RULE2: Identify ignored while erase or program busy.
// RULE3: Select high stops driving, returns to standby.
// RULE4: Unique identifier only on single-line identify.
// RULE5: Single-line on line zero; multi-line dual/quad.
// RULE6: Manufacturer byte, then type, then capacity.
// RULE7: First unique byte is length, value 10h.
// RULE8: Two extended bytes, then fourteen factory bytes.
// RULE9: Extended byte zero carries scheme and pin bits.
// RULE10: Table read: command, three address, eight dummies.
// RULE11: Table bytes increment, wrap at 2048 to zero.
// RULE12: Table read always continuous, ignores burst wrap.
// RULE13: Table bytes 0-3 hold the signature.
// RULE14: Bytes 4-7: revisions, header count, FFh.
// RULE15: Header zero: id, revisions, length, pointer, FFh.
// RULE16: Table bytes 10h-1Fh read as FFh.
// RULE17: Sample on rising edge, drive on falling.
module fir_readout #(
    parameter logic [7:0]   CMD_ID_SINGLE = 8'h9f,
    parameter logic [7:0]   CMD_ID_MULTI  = 8'haf,
    parameter logic [7:0]   CMD_TABLE     = 8'h5a,
    parameter logic [7:0]   MFR_CODE      = 8'h5c,   // Arbitrary value.
    parameter logic [7:0]   MEM_TYPE      = 8'h6d,   // Arbitrary value.
    parameter logic [7:0]   MEM_CAPACITY  = 8'h7e,   // Arbitrary value.
    parameter logic [7:0]   EXT_ID_BYTE1  = 8'h00,
    parameter logic [111:0] FACTORY_DATA  = {14{8'h00}}
) (
    // System clock and reset.
    input  wire logic             clock,
    input  wire logic             rst,
    // Configuration and status from the rest of the device.
    input  wire fir_pkg::fir_proto_t proto,
    input  wire logic             program_erase_busy,
    input  wire logic             alt_protect_scheme,
    input  wire logic             pin_is_reset,
    // Serial link pins.
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic [3:0]       serial_data_lines_i,
    output logic      [3:0]       serial_data_lines_o,
    output logic      [3:0]       serial_data_lines_oe_n,
    // Link status reported on the system clock.
    output logic                  select_active_r,
    output logic                  id_rejected_r
);

    // Registered copy of the configuration, the only source the link samples.
    fir_pkg::fir_cfg_t cfg_r;

    // Link-side synchronised configuration.
    fir_pkg::fir_cfg_t cfg_meta_r;
    fir_pkg::fir_cfg_t cfg_link_r;

    // Link sequencer.
    fir_pkg::fir_state_t state_r;
    logic [7:0]          cmd_r;
    logic [4:0]          cnt_r;
    logic [23:0]         addr_r;
    logic                multi_r;
    logic [2:0]          step_r;
    logic [4:0]          idx_r;
    logic [10:0]         taddr_r;
    logic                rej_tgl_r;

    // Combinational view of the incoming command and of the byte going out.
    logic [7:0]          cmd_nxt;
    logic [2:0]          cmd_last;
    logic [2:0]          step_last;
    logic [7:0]          out_byte;

    // System-side synchronisers.
    logic                cs_meta_r;
    logic                cs_sync_r;
    logic                rej_meta_r;
    logic                rej_sync_r;
    logic                rej_seen_r;

    // Shift the data lines into a command byte at the active protocol width.
    function automatic logic [7:0] shift_cmd(input logic [7:0] sh,
                                             input logic [3:0] dq,
                                             input fir_pkg::fir_proto_t p);
        case (p)
            fir_pkg::FIR_PROTO_DUAL: shift_cmd = {sh[5:0], dq[1:0]};
            fir_pkg::FIR_PROTO_QUAD: shift_cmd = {sh[3:0], dq[3:0]};
            default:                 shift_cmd = {sh[6:0], dq[0]};
        endcase
    endfunction : shift_cmd

    // Identify sequence contents by byte position.
    function automatic logic [7:0] id_byte(input logic [4:0] idx,
                                           input logic       multi,
                                           input fir_pkg::fir_cfg_t c);
        logic [7:0] ext0;
        ext0 = 8'h00;
        ext0[fir_pkg::FIR_EXT0_ALT] = c.alt_protect;     // RULE9
        ext0[fir_pkg::FIR_EXT0_PIN] = c.pin_is_reset;    // RULE9
        if (multi && idx > fir_pkg::FIR_IDX_CAP) begin
            id_byte = fir_pkg::FIR_PAST_END;             // RULE4
        end else begin
            case (idx)
                fir_pkg::FIR_IDX_MFR:  id_byte = MFR_CODE;       // RULE6
                fir_pkg::FIR_IDX_TYPE: id_byte = MEM_TYPE;       // RULE6
                fir_pkg::FIR_IDX_CAP:  id_byte = MEM_CAPACITY;   // RULE6
                fir_pkg::FIR_IDX_LEN:  id_byte = fir_pkg::FIR_UID_LEN; // RULE7
                fir_pkg::FIR_IDX_EXT0: id_byte = ext0;           // RULE8
                fir_pkg::FIR_IDX_EXT1: id_byte = EXT_ID_BYTE1;   // RULE8
                default: begin
                    if (idx >= fir_pkg::FIR_IDX_FAC0 && idx < fir_pkg::FIR_IDX_END) begin
                        // Factory bytes leave most significant byte first.
                        id_byte = FACTORY_DATA[8'(111 - 8 * (idx - fir_pkg::FIR_IDX_FAC0)) -: 8]; // RULE8
                    end else begin
                        id_byte = fir_pkg::FIR_PAST_END;
                    end
                end
            endcase
        end
    endfunction : id_byte

    // Discovery table contents; everything past the headers reads as fill.
    function automatic logic [7:0] table_byte(input logic [10:0] a);
        case (a)
            11'h000: table_byte = fir_pkg::FIR_SIG0;          // RULE13
            11'h001: table_byte = fir_pkg::FIR_SIG1;          // RULE13
            11'h002: table_byte = fir_pkg::FIR_SIG2;          // RULE13
            11'h003: table_byte = fir_pkg::FIR_SIG3;          // RULE13
            11'h004: table_byte = fir_pkg::FIR_REV_MINOR;     // RULE14
            11'h005: table_byte = fir_pkg::FIR_REV_MAJOR;     // RULE14
            11'h006: table_byte = fir_pkg::FIR_HDR_COUNT;     // RULE14
            11'h007: table_byte = fir_pkg::FIR_FILL;          // RULE14
            11'h008: table_byte = fir_pkg::FIR_PID0;          // RULE15
            11'h009: table_byte = fir_pkg::FIR_REV_MINOR;     // RULE15
            11'h00a: table_byte = fir_pkg::FIR_REV_MAJOR;     // RULE15
            11'h00b: table_byte = fir_pkg::FIR_PLEN_DW;       // RULE15
            11'h00c: table_byte = fir_pkg::FIR_PTR_LOW;       // RULE15
            11'h00d: table_byte = fir_pkg::FIR_ZERO;          // RULE15
            11'h00e: table_byte = fir_pkg::FIR_ZERO;          // RULE15
            default: table_byte = fir_pkg::FIR_FILL;          // RULE15 RULE16
        endcase
    endfunction : table_byte

    // Pick the bits of a byte that go out at a given step, most significant first.
    function automatic logic [1:0] pick_bits(input logic [7:0] b,
                                             input logic [2:0] step,
                                             input logic       two);
        logic [7:0] t;
        t = two ? (b << {step[1:0], 1'b0}) : (b << step);
        pick_bits = two ? t[7:6] : {1'b0, t[7]};
    endfunction : pick_bits

    // Capture configuration on the system clock so the link sees registered levels only.
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= '{proto: fir_pkg::FIR_PROTO_EXT, busy: 1'b0,
                       alt_protect: 1'b0, pin_is_reset: 1'b0};
        end else begin
            cfg_r <= '{proto: proto, busy: program_erase_busy,
                       alt_protect: alt_protect_scheme, pin_is_reset: pin_is_reset};
        end
    end

    // Two-stage crossing of the configuration onto the serial clock.
    // No select reset here: the values must survive between frames, since the
    // serial clock stands still while the link is idle.
    always_ff @(posedge sclk) begin
        cfg_meta_r <= cfg_r;
        cfg_link_r <= cfg_meta_r;
    end

    // Command width in clock steps and output step count per byte.
    always_comb begin
        cmd_nxt = shift_cmd(cmd_r, serial_data_lines_i, cfg_link_r.proto);
        case (cfg_link_r.proto)
            fir_pkg::FIR_PROTO_DUAL: cmd_last = 3'h3;
            fir_pkg::FIR_PROTO_QUAD: cmd_last = 3'h1;
            default:                 cmd_last = 3'h7;
        endcase                                                  // RULE5
        step_last = multi_r ? 3'h3 : 3'h7;
    end

    // Link sequencer, sampling on rising serial clock; select high clears it at once.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin                                          // RULE3
            state_r <= fir_pkg::FIR_ST_CMD;
            cmd_r   <= 8'h00;
            cnt_r   <= 5'h00;
            addr_r  <= 24'h000000;
            multi_r <= 1'b0;
            step_r  <= 3'h0;
            idx_r   <= 5'h00;
            taddr_r <= 11'h000;
        end else begin
            case (state_r)
                fir_pkg::FIR_ST_CMD: begin                       // RULE17
                    cmd_r <= cmd_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r[2:0] == cmd_last) begin
                        cnt_r <= 5'h00;
                        if (cmd_nxt == CMD_ID_SINGLE &&
                            cfg_link_r.proto == fir_pkg::FIR_PROTO_EXT &&
                            !cfg_link_r.busy) begin              // RULE1 RULE2 RULE5
                            state_r <= fir_pkg::FIR_ST_ID;
                            multi_r <= 1'b0;
                        end else if (cmd_nxt == CMD_ID_MULTI &&
                                     cfg_link_r.proto != fir_pkg::FIR_PROTO_EXT &&
                                     !cfg_link_r.busy) begin     // RULE1 RULE2 RULE5
                            state_r <= fir_pkg::FIR_ST_ID;
                            multi_r <= 1'b1;
                        end else if (cmd_nxt == CMD_TABLE &&
                                     cfg_link_r.proto == fir_pkg::FIR_PROTO_EXT) begin // RULE10
                            state_r <= fir_pkg::FIR_ST_ADDR;
                        end else begin
                            state_r <= fir_pkg::FIR_ST_IGNORE;
                        end
                    end
                end
                fir_pkg::FIR_ST_ADDR: begin
                    // Always three address bytes, whatever the addressing mode.
                    addr_r <= {addr_r[22:0], serial_data_lines_i[0]};  // RULE10
                    cnt_r  <= cnt_r + 5'h01;
                    if (cnt_r == fir_pkg::FIR_ADDR_LAST) begin
                        cnt_r   <= 5'h00;
                        state_r <= fir_pkg::FIR_ST_DUMMY;
                    end
                end
                fir_pkg::FIR_ST_DUMMY: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == fir_pkg::FIR_DUMMY_LAST) begin  // RULE10
                        state_r <= fir_pkg::FIR_ST_TABLE;
                        taddr_r <= addr_r[10:0];
                    end
                end
                fir_pkg::FIR_ST_ID: begin
                    step_r <= step_r + 3'h1;
                    if (step_r == step_last) begin
                        step_r <= 3'h0;
                        // Hold at the end position; further clocks return filler.
                        if (idx_r != fir_pkg::FIR_IDX_END) begin
                            idx_r <= idx_r + 5'h01;              // RULE6
                        end
                    end
                end
                fir_pkg::FIR_ST_TABLE: begin
                    step_r <= step_r + 3'h1;
                    if (step_r == 3'h7) begin
                        // Plain increment; the 11-bit pointer wraps by itself and no
                        // burst-wrap length is consulted.
                        taddr_r <= taddr_r + 11'h001;            // RULE11 RULE12
                    end
                end
                fir_pkg::FIR_ST_IGNORE: begin
                    // Rest of the frame is dropped until select rises.
                    state_r <= fir_pkg::FIR_ST_IGNORE;           // RULE2
                end
                default: begin
                    state_r <= fir_pkg::FIR_ST_IGNORE;
                end
            endcase
        end
    end

    // Toggle once per identify command refused for a busy array.
    // Reset by the system reset only, so the toggle survives frame ends.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rej_tgl_r <= 1'b0;
        end else if (!cs_n && state_r == fir_pkg::FIR_ST_CMD &&
                     cnt_r[2:0] == cmd_last && cfg_link_r.busy &&
                     (cmd_nxt == CMD_ID_SINGLE || cmd_nxt == CMD_ID_MULTI)) begin // RULE2
            rej_tgl_r <= ~rej_tgl_r;
        end
    end

    // Byte currently being shifted out.
    always_comb begin
        if (state_r == fir_pkg::FIR_ST_TABLE) begin
            out_byte = table_byte(taddr_r);
        end else begin
            out_byte = id_byte(idx_r, multi_r, cfg_link_r);
        end
    end

    // Output lines change on the falling serial clock edge; select high releases them
    // immediately so the host never fights a stale driver.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin                                          // RULE3
            serial_data_lines_o    <= 4'h0;
            serial_data_lines_oe_n <= fir_pkg::FIR_OE_NONE;
        end else begin
            case (state_r)
                fir_pkg::FIR_ST_ID: begin                        // RULE17
                    if (multi_r) begin
                        serial_data_lines_o    <= {2'b00, pick_bits(out_byte, step_r, 1'b1)};
                        serial_data_lines_oe_n <= fir_pkg::FIR_OE_LINES01;   // RULE5
                    end else begin
                        serial_data_lines_o    <= {2'b00, pick_bits(out_byte, step_r, 1'b0)};
                        serial_data_lines_oe_n <= fir_pkg::FIR_OE_LINE0;     // RULE5
                    end
                end
                fir_pkg::FIR_ST_TABLE: begin                     // RULE17
                    serial_data_lines_o    <= {1'b0, pick_bits(out_byte, step_r, 1'b0), 1'b0};
                    serial_data_lines_oe_n <= fir_pkg::FIR_OE_LINE1;
                end
                default: begin
                    serial_data_lines_o    <= 4'h0;
                    serial_data_lines_oe_n <= fir_pkg::FIR_OE_NONE;
                end
            endcase
        end
    end

    // Select pin and refusal toggle brought onto the system clock.
    always_ff @(posedge clock) begin
        if (rst) begin
            cs_meta_r  <= 1'b1;
            cs_sync_r  <= 1'b1;
            rej_meta_r <= 1'b0;
            rej_sync_r <= 1'b0;
        end else begin
            cs_meta_r  <= cs_n;
            cs_sync_r  <= cs_meta_r;
            rej_meta_r <= rej_tgl_r;
            rej_sync_r <= rej_meta_r;
        end
    end

    // Status outputs: select level and a one-cycle pulse per identify refused for a busy array.
    always_ff @(posedge clock) begin
        if (rst) begin
            rej_seen_r      <= 1'b0;
            select_active_r <= 1'b0;
            id_rejected_r   <= 1'b0;
        end else begin
            rej_seen_r      <= rej_sync_r;
            select_active_r <= ~cs_sync_r;
            id_rejected_r   <= rej_sync_r ^ rej_seen_r;
        end
    end

endmodule : fir_readout
